// File: rtl/ddcdn_pkg.sv
// package: constants, types and register map of the ddc3 config block
package ddcdn_pkg;
  // ==========================================
  // register indices, byte address = 4 * index
  localparam logic [11:0] IDX_CTRL = 12'h370;
  localparam logic [11:0] IDX_INSEL = 12'h371;
  localparam logic [11:0] IDX_NCOCTL = 12'h374;
  localparam logic [11:0] IDX_RATE = 12'h37e;
  localparam logic [11:0] IDX_STAT = 12'h37f;
  // ==========================================
  // field positions
  localparam int CTRL_C2R_BIT = 3;
  localparam int INSEL_Q_BIT = 2;
  localparam int INSEL_I_BIT = 0;
  // ==========================================
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] EXT_RST = 4'h0;
  localparam logic Q_SRC_RST = 1'b1;
  localparam logic I_SRC_RST = 1'b1;
  localparam logic [7:0] NCOCTL_RST = 8'h00;
  // ==========================================
  // selector codes
  localparam logic [2:0] SEL_EXT = 3'b111;
  // ==========================================
  // channel select modes
  typedef enum logic [3:0] {
    MODE_REGMAP = 4'b0000,
    MODE_PINS = 4'b0001,
    MODE_EDGE_LOW = 4'b1000,
    MODE_EDGE_HIGH = 4'b1010
  } ddcdn_mode_e;
  // ==========================================
  // stage enable bit positions
  localparam int ST_HALF1 = 0;
  localparam int ST_HALF2 = 1;
  localparam int ST_HALF3 = 2;
  localparam int ST_HALF4 = 3;
  localparam int ST_TB = 4;
  localparam int ST_FB = 5;
  // ==========================================
  // filter route: stage enables and overall decimation factor
  typedef struct packed {
    logic [5:0] stages;
    logic [5:0] factor;
  } ddcdn_route_s;
  localparam ddcdn_route_s ROUTE_RST = '{stages: 6'h03, factor: 6'h04};
endpackage

// File: rtl/ddcdn_top.sv
// ddc3 decimation route and oscillator channel select with apb registers
`timescale 1ns/1ps

// Functional notes
// [R01] three-bit chain selector in control low bits
// [R02] real-only output halves the decimation factor
// [R03] code 011: stage one only, 1 or 2
// [R04] code 100: stage one plus thirdband, 3 or 6
// [R05] code 101: halfbands one, two, thirdband
// [R06] code 110: halfbands one to three, thirdband
// [R07] code 111 defers to extended field
// [R08] extended field ignored unless selector all ones
// [R09] extended 0: thirdband plus four halfbands
// [R10] extended 2: fifthband plus halfband one
// [R11] extended 3: fifthband plus halfbands two, one
// [R12] extended 4: fifthband plus halfbands three..one
// [R13] quadrature source: 0 A, 1 B, reset 1
// [R14] in-phase source: 0 A, 1 B, reset 1
// [R15] mode 0 takes channel from register field
// [R16] mode 1: channel is zero, zero, high, low pins
// [R17] mode 1000 counts low pin rising edges
// [R18] mode 1010 counts high pin rising edges
// [R19] edge counter wraps at register field value
// [R20] register field n selects channel n
// [R21] mode nibble upper, resets zero
// [R22] pins synchronised, counter returns to zero
// [R23] reserved codes keep previous valid behaviour
module ddcdn_top #(
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic channel_select_pin_low,
  input wire logic channel_select_pin_high,
  output ddcdn_pkg::ddcdn_route_s filter_route,
  output logic real_only,
  output logic i_src_b,
  output logic q_src_b,
  output logic [3:0] nco_channel
);

  // ==========================================
  // functions
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [11:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  // valid flag, then route; complex factor halved when real only
  function automatic logic [12:0] decode(input logic [2:0] sel,
                                          input logic [3:0] ext,
                                          input logic c2r);
    logic [5:0] st;
    logic [5:0] f;
    logic ok;
    st = 6'h00;
    f = 6'h00;
    ok = 1'b1;
    unique case (sel)
      3'b000: begin
        st = 6'h03;
        f = 6'h04;
      end
      3'b001: begin
        st = 6'h07;
        f = 6'h08;
      end
      3'b010: begin
        st = 6'h0f;
        f = 6'h10;
      end
      3'b011: begin
        st = 6'h01; // [R03]
        f = 6'h02;
      end
      3'b100: begin
        st = 6'h11; // [R04]
        f = 6'h06;
      end
      3'b101: begin
        st = 6'h13; // [R05]
        f = 6'h0c;
      end
      3'b110: begin
        st = 6'h17; // [R06]
        f = 6'h18;
      end
      3'b111: begin
        // extended field used only here [R07] [R08]
        unique case (ext)
          4'h0: begin
            st = 6'h1f; // [R09]
            f = 6'h30;
          end
          4'h2: begin
            st = 6'h21; // [R10]
            f = 6'h0a;
          end
          4'h3: begin
            st = 6'h23; // [R11]
            f = 6'h14;
          end
          4'h4: begin
            st = 6'h27; // [R12]
            f = 6'h28;
          end
          default: ok = 1'b0; // [R23]
        endcase
      end
    endcase
    if (c2r) begin
      f = f >> 1; // [R02]
    end
    decode = {ok, st, f};
  endfunction

  // ==========================================
  // register fields
  logic [7:0] ctrl_q;
  logic [3:0] ext_q;
  logic q_src_q;
  logic i_src_q;
  logic [3:0] mode_q;
  logic [3:0] chsel_q;

  // ==========================================
  // apb slave, one wait state
  logic acc;
  logic wr_en;
  logic map_hit;
  logic [7:0] rd_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  assign acc = psel && penable && !pready_q;
  assign wr_en = psel && penable && pready_q && pwrite && pstrb[0]
                 && !pslverr_q;
  assign map_hit = hit(paddr, ddcdn_pkg::IDX_CTRL)
                   || hit(paddr, ddcdn_pkg::IDX_INSEL)
                   || hit(paddr, ddcdn_pkg::IDX_NCOCTL)
                   || hit(paddr, ddcdn_pkg::IDX_RATE)
                   || hit(paddr, ddcdn_pkg::IDX_STAT);

  logic [3:0] cnt_q;
  logic [3:0] nco_q;
  ddcdn_pkg::ddcdn_route_s route_q;

  always_comb begin
    rd_d = 8'h00;
    if (hit(paddr, ddcdn_pkg::IDX_CTRL)) begin
      rd_d = ctrl_q;
    end else if (hit(paddr, ddcdn_pkg::IDX_INSEL)) begin
      rd_d = {ext_q, 1'b0, q_src_q, 1'b0, i_src_q};
    end else if (hit(paddr, ddcdn_pkg::IDX_NCOCTL)) begin
      rd_d = {mode_q, chsel_q}; // [R21]
    end else if (hit(paddr, ddcdn_pkg::IDX_RATE)) begin
      rd_d = {2'b00, route_q.factor};
    end else if (hit(paddr, ddcdn_pkg::IDX_STAT)) begin
      rd_d = {cnt_q, nco_q};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc;
      pslverr_q <= acc && !map_hit;
      if (acc) begin
        prdata_q <= {24'h00_0000, rd_d};
      end
    end
  end

  // ==========================================
  // register writes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q <= ddcdn_pkg::CTRL_RST;
    end else if (wr_en && hit(paddr, ddcdn_pkg::IDX_CTRL)) begin
      ctrl_q <= pwdata[7:0]; // [R01]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ext_q <= ddcdn_pkg::EXT_RST;
      q_src_q <= ddcdn_pkg::Q_SRC_RST; // [R13]
      i_src_q <= ddcdn_pkg::I_SRC_RST; // [R14]
    end else if (wr_en && hit(paddr, ddcdn_pkg::IDX_INSEL)) begin
      ext_q <= pwdata[7:4];
      q_src_q <= pwdata[ddcdn_pkg::INSEL_Q_BIT]; // [R13]
      i_src_q <= pwdata[ddcdn_pkg::INSEL_I_BIT]; // [R14]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_q <= ddcdn_pkg::NCOCTL_RST[7:4]; // [R21]
      chsel_q <= ddcdn_pkg::NCOCTL_RST[3:0];
    end else if (wr_en && hit(paddr, ddcdn_pkg::IDX_NCOCTL)) begin
      mode_q <= pwdata[7:4]; // [R21]
      chsel_q <= pwdata[3:0];
    end
  end

  // ==========================================
  // filter route
  logic [12:0] dec;
  logic c2r;

  assign c2r = ctrl_q[ddcdn_pkg::CTRL_C2R_BIT];
  assign dec = decode(ctrl_q[2:0], ext_q, c2r);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      route_q <= ddcdn_pkg::ROUTE_RST;
    end else if (dec[12]) begin
      route_q <= dec[11:0]; // [R01] [R23]
    end
  end

  // ==========================================
  // pin synchronisers and edge detect
  logic lo_s1;
  logic lo_s2;
  logic lo_s3;
  logic hi_s1;
  logic hi_s2;
  logic hi_s3;
  logic rise_lo;
  logic rise_hi;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lo_s1 <= 1'b0;
      lo_s2 <= 1'b0;
      lo_s3 <= 1'b0;
      hi_s1 <= 1'b0;
      hi_s2 <= 1'b0;
      hi_s3 <= 1'b0;
    end else begin
      lo_s1 <= channel_select_pin_low; // [R22]
      lo_s2 <= lo_s1;
      lo_s3 <= lo_s2;
      hi_s1 <= channel_select_pin_high;
      hi_s2 <= hi_s1;
      hi_s3 <= hi_s2;
    end
  end

  assign rise_lo = lo_s2 && !lo_s3;
  assign rise_hi = hi_s2 && !hi_s3;

  // ==========================================
  // edge counter
  logic step;

  assign step = (mode_q == ddcdn_pkg::MODE_EDGE_LOW && rise_lo) // [R17]
                || (mode_q == ddcdn_pkg::MODE_EDGE_HIGH && rise_hi); // [R18]

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_q <= 4'h0;
    end else if (step) begin
      if (cnt_q >= chsel_q) begin
        cnt_q <= 4'h0; // [R19] [R22]
      end else begin
        cnt_q <= cnt_q + 4'h1; // [R17] [R18]
      end
    end
  end

  // ==========================================
  // active channel
  logic [3:0] nco_d;

  always_comb begin
    nco_d = nco_q; // [R23]
    case (mode_q)
      ddcdn_pkg::MODE_REGMAP: nco_d = chsel_q; // [R15] [R20]
      ddcdn_pkg::MODE_PINS: nco_d = {2'b00, hi_s2, lo_s2}; // [R16]
      ddcdn_pkg::MODE_EDGE_LOW: nco_d = cnt_q;
      ddcdn_pkg::MODE_EDGE_HIGH: nco_d = cnt_q;
      default: nco_d = nco_q;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      nco_q <= 4'h0;
    end else begin
      nco_q <= nco_d;
    end
  end

  // ==========================================
  // output flops
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      real_only <= 1'b0;
      i_src_b <= ddcdn_pkg::I_SRC_RST;
      q_src_b <= ddcdn_pkg::Q_SRC_RST;
    end else begin
      real_only <= c2r; // [R02]
      i_src_b <= i_src_q;
      q_src_b <= q_src_q;
    end
  end

  assign filter_route = route_q;
  assign nco_channel = nco_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ==========================================
  // assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  sequence s_access;
    psel && penable && !pready;
  endsequence

  sequence s_answer;
    pready ##1 !pready;
  endsequence

  a_apb_answer: assert property (s_access |=> s_answer)
    else $error("apb answer not after one wait state");

  a_code_three: assert property ( // [R03]
    ctrl_q[2:0] == 3'b011 |=> filter_route.stages == 6'h01
    && filter_route.factor == ($past(c2r) ? 6'h01 : 6'h02))
    else $error("code 011 route wrong");

  a_code_four: assert property ( // [R04]
    ctrl_q[2:0] == 3'b100 && c2r |=> filter_route.factor == 6'h03)
    else $error("code 100 factor wrong");

  a_code_six: assert property ( // [R06]
    ctrl_q[2:0] == 3'b110 && !c2r |=> filter_route == 12'h5d8)
    else $error("code 110 route wrong");

  a_ext_zero: assert property ( // [R09]
    ctrl_q[2:0] == 3'b111 && ext_q == 4'h0 && !c2r
    |=> filter_route.factor == 6'h30 && filter_route.stages == 6'h1f)
    else $error("extended 0 route wrong");

  a_ext_gate: assert property ( // [R08]
    ctrl_q[2:0] != 3'b111 |=> !filter_route.stages[ddcdn_pkg::ST_FB])
    else $error("fifthband used without extended code");

  a_reserved_hold: assert property ( // [R23]
    ctrl_q[2:0] == 3'b111 && ext_q > 4'h4 |=> $stable(filter_route))
    else $error("reserved code changed route");

  a_pins_mode: assert property ( // [R16]
    mode_q == ddcdn_pkg::MODE_PINS
    |=> nco_channel == {2'b00, $past(hi_s2), $past(lo_s2)})
    else $error("pin mode channel wrong");

  a_regmap_mode: assert property ( // [R20]
    mode_q == ddcdn_pkg::MODE_REGMAP |=> nco_channel == $past(chsel_q))
    else $error("register map channel wrong");

  a_edge_step: assert property ( // [R17]
    mode_q == ddcdn_pkg::MODE_EDGE_LOW && rise_lo && cnt_q < chsel_q
    |=> cnt_q == $past(cnt_q) + 4'h1 ##1 nco_channel == $past(cnt_q))
    else $error("low pin edge did not step counter");

  a_edge_wrap: assert property ( // [R19]
    step && cnt_q >= chsel_q |=> cnt_q == 4'h0)
    else $error("counter did not wrap");

  a_src_reset: assert property ( // [R14]
    $fell(srst) |-> i_src_b && q_src_b)
    else $error("input sources not reset to channel b");

endmodule // ddcdn_top

// File: sim/ddcdn_pin_ctrl.sv
// far-side controller model driving the two channel select pins
`timescale 1ns/1ps
module ddcdn_pin_ctrl (
  input wire logic sys_clk,
  output logic pin_low,
  output logic pin_high
);
  // ==========
  // pins idle low at time zero
  initial begin
    pin_low = 1'b0;
    pin_high = 1'b0;
  end
  // ==========
  // drive both pin levels just after a rising edge
  task automatic set_pins(input logic lo, input logic hi);
    @(posedge sys_clk);
    pin_low <= lo;
    pin_high <= hi;
  endtask
  // one rising edge on one pin: three cycles high, two low
  task automatic pulse(input logic on_high);
    set_pins(!on_high, on_high);
    repeat (2) @(posedge sys_clk);
    set_pins(1'b0, 1'b0);
    repeat (2) @(posedge sys_clk);
  endtask
endmodule // ddcdn_pin_ctrl

// File: sim/ddcdn_top_bench.sv
// self-checking bench for the ddc3 route and channel select block
`timescale 1ns/1ps
module ddcdn_top_bench;
  logic sys_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, nco_channel;
  logic pin_low, pin_high, real_only, i_src_b, q_src_b, err;
  ddcdn_pkg::ddcdn_route_s filter_route;
  int num_errors = 0;
  int total_checks = 0;
  logic [5:0] st_t [8] = '{6'h01, 6'h11, 6'h13, 6'h17,
                           6'h1f, 6'h21, 6'h23, 6'h27};
  logic [5:0] f_t [8] = '{6'd2, 6'd6, 6'd12, 6'd24,
                          6'd48, 6'd10, 6'd20, 6'd40};
  logic [3:0] x_t [4] = '{4'h0, 4'h2, 4'h3, 4'h4};

  ddcdn_top #(.ADDR_W(16)) dut (.sys_clk(sys_clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .channel_select_pin_low(pin_low),
    .channel_select_pin_high(pin_high), .filter_route(filter_route),
    .real_only(real_only), .i_src_b(i_src_b), .q_src_b(q_src_b),
    .nco_channel(nco_channel));
  ddcdn_pin_ctrl ctrl (.sys_clk(sys_clk), .pin_low(pin_low),
    .pin_high(pin_high));

  // ==========
  // clock, verdict and shared tasks
  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;
  task automatic wrap_up();
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] idx,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= 16'({idx, 2'b00});
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic route(input logic [5:0] st, input logic [5:0] f);
    repeat (3) @(posedge sys_clk);
    chk("stages", 32'(filter_route.stages), 32'(st));
    chk("factor", 32'(filter_route.factor), 32'(f));
  endtask

  // ==========
  // scenarios
  task automatic t_reset();
    chk("i_src_b", 32'(i_src_b), 32'h1);
    chk("q_src_b", 32'(q_src_b), 32'h1);
    chk("nco_channel", 32'(nco_channel), 32'h0);
    apb(1'b0, ddcdn_pkg::IDX_INSEL, 8'h00);
    chk("insel", rd, 32'h05);
    apb(1'b0, ddcdn_pkg::IDX_NCOCTL, 8'h00);
    chk("ncoctl", rd, 32'h00);
  endtask
  task automatic t_sel();
    for (int i = 0; i < 4; i++) begin
      for (int c = 0; c < 2; c++) begin
        apb(1'b1, ddcdn_pkg::IDX_CTRL, {4'h0, 1'(c), 3'(i + 3)});
        route(st_t[i], f_t[i] >> c);
        chk("real_only", 32'(real_only), 32'(c));
      end
    end
  endtask
  task automatic t_ext();
    apb(1'b1, ddcdn_pkg::IDX_INSEL, 8'h25);
    route(6'h17, 6'd12);
    for (int i = 0; i < 4; i++) begin
      for (int c = 0; c < 2; c++) begin
        apb(1'b1, ddcdn_pkg::IDX_INSEL, {x_t[i], 4'h5});
        apb(1'b1, ddcdn_pkg::IDX_CTRL, {4'h0, 1'(c), 3'b111});
        route(st_t[i + 4], f_t[i + 4] >> c);
      end
    end
    apb(1'b1, ddcdn_pkg::IDX_INSEL, 8'h55);
    route(6'h27, 6'd20);
    apb(1'b0, ddcdn_pkg::IDX_RATE, 8'h00);
    chk("rate", rd, 32'h14);
    chk("pslverr", 32'(err), 32'h0);
  endtask
  task automatic t_insel();
    apb(1'b1, ddcdn_pkg::IDX_INSEL, 8'h04);
    repeat (3) @(posedge sys_clk);
    chk("i_src_b", 32'(i_src_b), 32'h0);
    chk("q_src_b", 32'(q_src_b), 32'h1);
    apb(1'b1, ddcdn_pkg::IDX_INSEL, 8'h0b);
    repeat (3) @(posedge sys_clk);
    chk("i_src_b", 32'(i_src_b), 32'h1);
    chk("q_src_b", 32'(q_src_b), 32'h0);
    apb(1'b0, ddcdn_pkg::IDX_INSEL, 8'h00);
    chk("insel", rd, 32'h01);
  endtask
  task automatic t_nco();
    logic [3:0] cnt;
    apb(1'b1, ddcdn_pkg::IDX_NCOCTL, 8'h0b);
    repeat (3) @(posedge sys_clk);
    chk("nco_channel", 32'(nco_channel), 32'hb);
    apb(1'b1, ddcdn_pkg::IDX_NCOCTL, 8'h10);
    for (int k = 0; k < 4; k++) begin
      ctrl.set_pins(k[0], k[1]);
      repeat (5) @(posedge sys_clk);
      chk("nco_channel", 32'(nco_channel), 32'(k));
    end
    apb(1'b1, ddcdn_pkg::IDX_NCOCTL, 8'h25);
    ctrl.set_pins(1'b0, 1'b0);
    repeat (5) @(posedge sys_clk);
    chk("nco_channel", 32'(nco_channel), 32'h3);
    apb(1'b1, ddcdn_pkg::IDX_NCOCTL, 8'h82);
    cnt = 4'h0;
    for (int j = 0; j < 6; j++) begin
      ctrl.pulse(j[2]);
      if (!j[2]) cnt = (cnt >= 4'h2) ? 4'h0 : cnt + 4'h1;
      repeat (2) @(posedge sys_clk);
      chk("nco_channel", 32'(nco_channel), 32'(cnt));
    end
    apb(1'b0, ddcdn_pkg::IDX_STAT, 8'h00);
    chk("stat", rd, 32'h11);
    apb(1'b1, ddcdn_pkg::IDX_NCOCTL, 8'ha2);
    for (int j = 0; j < 3; j++) begin
      ctrl.pulse(j != 2);
      if (j != 2) cnt = (cnt >= 4'h2) ? 4'h0 : cnt + 4'h1;
      repeat (2) @(posedge sys_clk);
      chk("nco_channel", 32'(nco_channel), 32'(cnt));
    end
  endtask

  // ==========
  // main sequence and watchdog
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_sel();
    t_ext();
    t_insel();
    t_nco();
    apb(1'b0, 12'h372, 8'h00);
    chk("pslverr", 32'(err), 32'h1);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end
endmodule // ddcdn_top_bench
